// ### hw/periph_irq_regs.svh
`ifndef PERIPH_IRQ_REGS_SVH
`define PERIPH_IRQ_REGS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define OFS_EVENT_FLAGS 8'h0c
`define OFS_EVENT_ENABLES 8'h10
`define OFS_IRQ_CONTROL 8'h14
`define OFS_FLAG_CLEAR 8'h18

// ****************************************************************
// flag bit positions
// ****************************************************************
`define BIT_NV_WRITE_DONE 7
`define BIT_CONVERSION_DONE 6
`define BIT_CAPTURE_COMPARE 5
`define BIT_UNUSED_FOUR 4
`define BIT_COMPARATOR_CHANGE 3
`define BIT_CLOCK_FAIL 2
`define BIT_PERIOD_MATCH 1
`define BIT_TIMER_ONE_OVERFLOW 0

// ****************************************************************
// irq control bit positions
// ****************************************************************
`define BIT_GLOBAL_IRQ_GATE 7
`define BIT_PERIPHERAL_IRQ_GATE 6

// ****************************************************************
// reset values and masks
// ****************************************************************
`define RST_EVENT_FLAGS 8'h00
`define RST_EVENT_ENABLES 8'h00
`define RST_IRQ_CONTROL 8'h00
`define MASK_IMPLEMENTED 8'hef
`define MASK_SW_SETTABLE 8'h6f
`define MASK_IRQ_CONTROL 8'hc0

`endif

// ### hw/periph_irq_pkg.sv
package periph_irq_pkg;
  typedef logic [7:0] flag_vec_t;
  typedef logic [31:0] apb_data_t;
  typedef logic [7:0] apb_addr_t;
  typedef enum logic [3:0] {
    SEL_FLAGS = 4'h1,
    SEL_ENABLES = 4'h2,
    SEL_CONTROL = 4'h4,
    SEL_CLEAR = 4'h8
  } reg_sel_t;
endpackage

// ### hw/flag_bit_cell.sv
module flag_bit_cell (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // event and software access
  input wire logic setEvent,
  input wire logic swWrite,
  input wire logic swValue,
  input wire logic swClearOne,
  input wire logic swSetAllowed,
  // state
  output logic flag_q
);
  logic flag_d;
  logic writeValue;

  // a bit that software may not set can only be cleared by a write
  assign writeValue = swSetAllowed ? swValue : (flag_q & swValue);
  // the event wins over a clear in the same cycle so no event is lost
  assign flag_d = setEvent ? 1'b1 :
                  swWrite ? writeValue :
                  swClearOne ? 1'b0 : flag_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule

// ### hw/peripheral_interrupt_flags.sv
// The implementer's own choice: the APB register port.
`include "periph_irq_regs.svh"
// How it works
// - flag register at 0x0c, cleared at reset
// - write done sets bit 7, software clears
// - bit 7 stays zero until a write completes
// - period match sets bit 1 until cleared
// - flags set regardless of any enable
// - request needs flag, enable and peripheral gate
// - enable bits align one-to-one with flags
module peripheral_interrupt_flags (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire periph_irq_pkg::apb_addr_t paddr,
  input wire periph_irq_pkg::apb_data_t pwdata,
  input wire logic [3:0] pstrb,
  output periph_irq_pkg::apb_data_t prdata,
  output logic pready,
  output logic pslverr,
  // peripheral event pulses
  input wire logic nvWriteDone,
  input wire logic conversionDone,
  input wire logic captureEvent,
  input wire logic compareMatch,
  input wire logic pwmMode,
  input wire logic comparatorChange,
  input wire logic clockFail,
  input wire logic periodMatch,
  input wire logic timerOneOverflow,
  // interrupt
  output logic periphIrq,
  output logic coreIrq
);
  import periph_irq_pkg::*;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // the access decode reads the registered ready, so it comes first
  logic pready_q;

  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable & pready_q;
  wire hitFlags = (paddr == `OFS_EVENT_FLAGS);
  wire hitEnables = (paddr == `OFS_EVENT_ENABLES);
  wire hitControl = (paddr == `OFS_IRQ_CONTROL);
  wire hitClear = (paddr == `OFS_FLAG_CLEAR);
  wire hitAny = hitFlags | hitEnables | hitControl | hitClear;
  // only byte lane zero carries a register, other lanes are ignored
  wire laneZero = pstrb[0];
  wire doWrite = accessDone & pwrite & hitAny & laneZero;
  wire wrFlags = doWrite & hitFlags;
  wire wrEnables = doWrite & hitEnables;
  wire wrControl = doWrite & hitControl;
  wire wrClear = doWrite & hitClear;
  wire [7:0] wrByte = pwdata[7:0];

  reg_sel_t regSel;
  assign regSel = hitFlags ? SEL_FLAGS :
                  hitEnables ? SEL_ENABLES :
                  hitControl ? SEL_CONTROL : SEL_CLEAR;

  // ****************************************************************
  // state
  // ****************************************************************
  logic pslverr_q;
  apb_data_t prdata_q;
  apb_data_t prdata_d;
  flag_vec_t flags;
  flag_vec_t enables_q;
  flag_vec_t enables_d;
  logic [7:0] control_q;
  logic [7:0] control_d;
  logic periphIrq_q;
  logic coreIrq_q;
  flag_vec_t eventVec;

  // ****************************************************************
  // event routing
  // ****************************************************************
  // capture/compare has no meaning in pwm mode, so its event is dropped
  wire ccpEvent = (captureEvent | compareMatch) & ~pwmMode;

  // events set flags whatever the enables hold, no enable is looked at here
  assign eventVec = {nvWriteDone,
                     conversionDone,
                     ccpEvent,
                     1'b0,
                     comparatorChange,
                     clockFail,
                     periodMatch,
                     timerOneOverflow};

  localparam flag_vec_t IMPL = `MASK_IMPLEMENTED;
  localparam flag_vec_t SWSET = `MASK_SW_SETTABLE;

  // ****************************************************************
  // flag cells
  // ****************************************************************
  // bit 4 has no cell, it is tied low and always reads zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gFlag
      if (IMPL[gi]) begin : gImpl
        flag_bit_cell uCell (
          .core_clk(core_clk),
          .rst_n(rst_n),
          .setEvent(eventVec[gi]),
          .swWrite(wrFlags),
          .swValue(wrByte[gi]),
          .swClearOne(wrClear & wrByte[gi]),
          .swSetAllowed(SWSET[gi]),
          .flag_q(flags[gi])
        );
      end else begin : gHole
        assign flags[gi] = 1'b0;
      end
    end
  endgenerate

  // ****************************************************************
  // enable and control registers
  // ****************************************************************
  assign enables_d = wrEnables ? (wrByte & IMPL) : enables_q;
  assign control_d = wrControl ? (wrByte & `MASK_IRQ_CONTROL)
                               : control_q;

  wire peripheralGate = control_q[`BIT_PERIPHERAL_IRQ_GATE];
  wire globalGate = control_q[`BIT_GLOBAL_IRQ_GATE];
  wire anyPending = |(flags & enables_q);
  wire periphIrq_d = anyPending & peripheralGate;
  wire coreIrq_d = periphIrq_d & globalGate;

  // ****************************************************************
  // read data, prepared in the setup phase for a zero wait answer
  // ****************************************************************
  always_comb begin
    prdata_d = '0;
    case (regSel)
      SEL_FLAGS: prdata_d[7:0] = flags;
      SEL_ENABLES: prdata_d[7:0] = enables_q;
      SEL_CONTROL: prdata_d[7:0] = control_q;
      SEL_CLEAR: prdata_d[7:0] = 8'h00;
      default: prdata_d[7:0] = 8'h00;
    endcase
    if (!hitAny) begin
      prdata_d = '0;
    end
  end

  // ready answers in the first access cycle, so no wait state is added
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setupPhase;
      pslverr_q <= setupPhase & ~hitAny;
    end
  end

  // read data holds after the access, so a late sample still sees it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= '0;
    end else begin
      prdata_q <= setupPhase ? prdata_d : prdata_q;
    end
  end

  // enables keep bit 4 at zero, so the hole can never raise a request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enables_q <= `RST_EVENT_ENABLES;
    end else begin
      enables_q <= enables_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_q <= `RST_IRQ_CONTROL;
    end else begin
      control_q <= control_d;
    end
  end

  // requests are registered: one cycle late, but glitch free at the pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      periphIrq_q <= 1'b0;
      coreIrq_q <= 1'b0;
    end else begin
      periphIrq_q <= periphIrq_d;
      coreIrq_q <= coreIrq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign periphIrq = periphIrq_q;
  assign coreIrq = coreIrq_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_flags_readback: assert property (
    setupPhase && hitFlags && !pwrite |=> prdata[7:0] == $past(flags)
  ) else $error("flag register read returned wrong value");

  a_nvdone_sets: assert property (
    nvWriteDone |=> flags[`BIT_NV_WRITE_DONE]
  ) else $error("write done did not set bit 7");

  a_nvflag_holds: assert property (
    flags[`BIT_NV_WRITE_DONE] && !wrFlags && !wrClear
    |=> flags[`BIT_NV_WRITE_DONE]
  ) else $error("bit 7 cleared by hardware");

  a_nvflag_cause: assert property (
    $rose(flags[`BIT_NV_WRITE_DONE]) |-> $past(nvWriteDone)
  ) else $error("bit 7 set without write completion");

  a_period_sticky: assert property (
    flags[`BIT_PERIOD_MATCH] && !wrFlags && !wrClear
    |=> flags[`BIT_PERIOD_MATCH]
  ) else $error("period match flag cleared by hardware");

  a_bit_four_zero: assert property (
    pready |-> !prdata[`BIT_UNUSED_FOUR]
  ) else $error("bit 4 read as one");

  a_pwm_ignored: assert property (
    pwmMode && !flags[`BIT_CAPTURE_COMPARE] && !wrFlags
    |=> !flags[`BIT_CAPTURE_COMPARE]
  ) else $error("capture flag set in pwm mode");

  a_event_ungated: assert property (
    periodMatch && enables_q == 8'h00 && control_q == 8'h00
    |=> flags[`BIT_PERIOD_MATCH]
  ) else $error("flag depended on enable");

  a_irq_needs_gate: assert property (
    periphIrq |-> $past(peripheralGate) && $past(anyPending)
  ) else $error("request raised without gate or flag");

  a_irq_raised: assert property (
    anyPending && peripheralGate ##1 anyPending |-> periphIrq
  ) else $error("request missing with flag, enable and gate");

  a_enable_align: assert property (
    flags == 8'h02 && enables_q == 8'h01 |=> !periphIrq
  ) else $error("enable gated a different flag position");

  // bus answer and the corner cases that plain scenarios rarely reach
  a_ready_one_cycle: assert property (
    pready |=> !pready
  ) else $error("ready stood longer than one cycle");

  a_unmapped_error: assert property (
    setupPhase && !hitAny |=> pready && pslverr
  ) else $error("unmapped access gave no error");

  a_nv_no_swset: assert property (
    wrFlags && !flags[`BIT_NV_WRITE_DONE] && !nvWriteDone
    |=> !flags[`BIT_NV_WRITE_DONE]
  ) else $error("software set the write done flag");

  a_event_wins: assert property (
    periodMatch && (wrFlags || wrClear) |=> flags[`BIT_PERIOD_MATCH]
  ) else $error("clear in the event cycle lost the event");

  a_clear_alias: assert property (
    wrClear && eventVec == 8'h00 |=> (flags & $past(wrByte)) == 8'h00
  ) else $error("clear alias left a flag set");

  a_strobe_ignored: assert property (
    accessDone && pwrite && hitEnables && !laneZero
    |=> enables_q == $past(enables_q)
  ) else $error("write without lane zero changed enables");

  a_core_gate: assert property (
    coreIrq |-> $past(globalGate) && $past(periphIrq_d)
  ) else $error("core request without global gate");

  c_nv_done: cover property (nvWriteDone ##1 flags[7]);
  c_irq_rise: cover property ($rose(periphIrq));
  c_set_clear: cover property (periodMatch && wrFlags);
  c_bad_addr: cover property (pslverr && pready);
  c_strobe_skip: cover property (accessDone && pwrite && !laneZero);
endmodule

// ### dv/periph_event_model.sv
// ****
// peripheral event sources: one request bit per event line
// ****
module periph_event_model (
  // request from the bench
  input wire periph_irq_pkg::flag_vec_t evReq,
  input wire logic pwmReq,
  // event lines toward the block
  output logic nvWriteDone,
  output logic conversionDone,
  output logic captureEvent,
  output logic compareMatch,
  output logic pwmMode,
  output logic comparatorChange,
  output logic clockFail,
  output logic periodMatch,
  output logic timerOneOverflow
);
  timeunit 1ns;
  timeprecision 1ns;
  import periph_irq_pkg::*;
  // bit 4 has no flag, so its request line is reused for compare match
  assign nvWriteDone = evReq[7];
  assign conversionDone = evReq[6];
  assign captureEvent = evReq[5];
  assign compareMatch = evReq[4];
  assign comparatorChange = evReq[3];
  assign clockFail = evReq[2];
  assign periodMatch = evReq[1];
  assign timerOneOverflow = evReq[0];
  assign pwmMode = pwmReq;
endmodule

// ### dv/test_peripheral_interrupt_flags.sv
module test_peripheral_interrupt_flags;
  timeunit 1ns;
  timeprecision 1ns;
  import periph_irq_pkg::*;
  logic coreClk, rst_n, psel, penable, pwrite, pready, pslverr, pwmReq;
  logic nvW, conv, capt, cmpM, pwm, cmpC, clkF, perM, t1o, pIrq, cIrq;
  logic [3:0] pstrb, strb;
  apb_addr_t paddr;
  apb_data_t pwdata, prdata, rdat;
  flag_vec_t evReq;
  int nMismatch, cmpCount, i;
  logic err;
  periph_event_model periph_event_model_i (.evReq(evReq), .pwmReq(pwmReq),
    .nvWriteDone(nvW), .conversionDone(conv), .captureEvent(capt),
    .compareMatch(cmpM), .pwmMode(pwm), .comparatorChange(cmpC),
    .clockFail(clkF), .periodMatch(perM), .timerOneOverflow(t1o));
  peripheral_interrupt_flags peripheral_interrupt_flags_i (
    .core_clk(coreClk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvWriteDone(nvW), .conversionDone(conv), .captureEvent(capt),
    .compareMatch(cmpM), .pwmMode(pwm), .comparatorChange(cmpC),
    .clockFail(clkF), .periodMatch(perM), .timerOneOverflow(t1o),
    .periphIrq(pIrq), .coreIrq(cIrq));
  // ****
  // checking and closing
  // ****
  task automatic testDone;
    $display("mismatches %0d compares %0d", nMismatch, cmpCount);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input apb_data_t seen, input apb_data_t exp);
    cmpCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // ****
  // apb master and event helpers
  // ****
  task automatic apb(input logic w, input apb_addr_t a, input apb_data_t d);
    int n;
    n = 0;
    @(posedge coreClk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge coreClk);
    penable <= 1'b1;
    do begin
      @(posedge coreClk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      nMismatch++;
      testDone();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input apb_addr_t a, input apb_data_t exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic fire(input flag_vec_t v);
    @(posedge coreClk);
    evReq <= v;
    @(posedge coreClk);
    evReq <= 8'h00;
  endtask
  task automatic irqSeen(input logic p, input logic c);
    repeat (2) @(posedge coreClk);
    #1;
    chk({30'h0, cIrq, pIrq}, {30'h0, c, p});
  endtask
  // ****
  // scenarios
  // ****
  task automatic resetValues;
    rd(8'h0c, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic eachEvent;
    for (i = 0; i < 8; i++) begin
      fire(flag_vec_t'(1 << i));
      // bit 4 request pulses compare match, which lands on bit 5
      rd(8'h0c, (i == 4) ? 32'h20 : 32'h1 << i);
      repeat (5) @(posedge coreClk);
      rd(8'h0c, (i == 4) ? 32'h20 : 32'h1 << i);
      apb(1'b1, 8'h0c, 32'h0);
      rd(8'h0c, 32'h0);
    end
  endtask
  task automatic swWrites;
    apb(1'b1, 8'h0c, 32'hff);
    rd(8'h0c, 32'h6f);
    apb(1'b1, 8'h18, 32'h0f);
    rd(8'h0c, 32'h60);
    apb(1'b1, 8'h0c, 32'h0);
    pwmReq <= 1'b1;
    fire(8'h30);
    rd(8'h0c, 32'h0);
    pwmReq <= 1'b0;
    // a write without byte lane zero must leave the register alone
    strb <= 4'he;
    apb(1'b1, 8'h10, 32'hff);
    strb <= 4'hf;
    rd(8'h10, 32'h0);
  endtask
  task automatic irqPath;
    apb(1'b1, 8'h10, 32'hff);
    rd(8'h10, 32'hef);
    apb(1'b1, 8'h10, 32'h02);
    fire(8'h02);
    irqSeen(1'b0, 1'b0);
    apb(1'b1, 8'h14, 32'h40);
    irqSeen(1'b1, 1'b0);
    apb(1'b1, 8'h14, 32'hc0);
    irqSeen(1'b1, 1'b1);
    apb(1'b1, 8'h10, 32'h01);
    irqSeen(1'b0, 1'b0);
    apb(1'b1, 8'h10, 32'h02);
    apb(1'b1, 8'h18, 32'h02);
    irqSeen(1'b0, 1'b0);
    // the event lands on the very edge that takes the clearing write
    fork
      apb(1'b1, 8'h0c, 32'h0);
      begin
        @(posedge coreClk);
        fire(8'h02);
      end
    join
    rd(8'h0c, 32'h2);
  endtask
  initial begin
    coreClk = 1'b0;
    forever #5 coreClk = ~coreClk;
  end
  initial begin
    {rst_n, psel, penable, pwrite, pwmReq} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strb = 4'hf;
    pstrb = 4'hf;
    evReq = 8'h00;
    nMismatch = 0;
    cmpCount = 0;
    repeat (4) @(posedge coreClk);
    rst_n <= 1'b1;
    resetValues();
    eachEvent();
    swWrites();
    irqPath();
    testDone();
  end
endmodule
